// ---- logic/rsmh_link_if.sv ----
// Byte-level half-duplex link between master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface rsmh_link_if;
   logic [7:0] qByte;
   logic qStb;
   logic qErr;
   logic [7:0] rByte;
   logic rValid;
   logic rReady;
   modport master(output qByte, output qStb, output qErr, input rByte, input rValid, output rReady);
   modport slave(input qByte, input qStb, input qErr, output rByte, output rValid, input rReady);
endinterface
`default_nettype wire

// ---- logic/rsmh_master.sv ----
// Master end: sends one query per command it does not refuse and gathers the answer
`timescale 1ns/1ps
`default_nettype none
module rsmh_master #(
   parameter int unsigned SILENCE_CYC = rsmh_pkg::SILENCE_CYC,
   parameter int unsigned RESP_CYC = rsmh_pkg::RESP_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   rsmh_link_if.master link,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdFunc,
   input wire logic [15:0] cmdWord0,
   input wire logic [15:0] cmdWord1,
   input wire logic rxStall,
   output logic respValid,
   output logic [2:0] respStatus,
   output logic [7:0] respFunc,
   output logic [7:0] respCode,
   output logic [15:0] respWord
);
   typedef enum logic [2:0] {M_IDLE, M_GAP, M_SEND, M_WAIT, M_DONE} rsmh_mst_t;

   localparam logic [rsmh_pkg::CNT_W-1:0] SIL = rsmh_pkg::CNT_W'(SILENCE_CYC);
   localparam logic [rsmh_pkg::CNT_W-1:0] RLIM = rsmh_pkg::CNT_W'(RESP_CYC);

   rsmh_mst_t state_reg;
   logic [7:0] qb_reg [6];
   logic [7:0] rb_reg [5];
   logic [2:0] idx_reg;
   logic [15:0] crc_reg;
   logic [7:0] rCnt_reg;
   logic [15:0] rCrc_reg;
   logic bcast_reg;
   logic refused_reg;
   logic [rsmh_pkg::CNT_W-1:0] idle_reg;
   logic [rsmh_pkg::CNT_W-1:0] wait_reg;
   logic [7:0] qByte_reg;
   logic qStb_reg;
   logic rReady_reg;
   logic cmdReady_reg;
   logic respValid_reg;
   logic [2:0] respStatus_reg;
   logic [15:0] respWord_reg;
   logic [7:0] respFunc_reg;
   logic [7:0] respCode_reg;
   logic take;
   logic refuse;
   logic [7:0] nextByte;

   assign link.qByte = qByte_reg;
   assign link.qStb = qStb_reg;
   assign link.qErr = 1'b0;
   assign link.rReady = rReady_reg;
   assign cmdReady = cmdReady_reg;
   assign respValid = respValid_reg;
   assign respStatus = respStatus_reg;
   assign respFunc = respFunc_reg;
   assign respCode = respCode_reg;
   assign respWord = respWord_reg;

   assign take = link.rValid && rReady_reg && state_reg == M_WAIT;
   // [R1] [R4] [R8] Refuse illegal commands
   assign refuse = cmdAddr > rsmh_pkg::ADDR_MAX || cmdFunc == 8'h00 ||
      (cmdAddr == rsmh_pkg::ADDR_BCAST && cmdFunc != rsmh_pkg::FN_WRITE);
   assign nextByte = (idx_reg == 3'h6) ? crc_reg[7:0] : (idx_reg == 3'h7) ? crc_reg[15:8] : qb_reg[idx_reg];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= '0;
      end else if (take || qStb_reg) begin
         idle_reg <= '0;
      end else if (idle_reg != SIL && !link.rValid) begin
         idle_reg <= idle_reg + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= M_IDLE;
         cmdReady_reg <= 1'b0;
         rReady_reg <= 1'b0;
         qStb_reg <= 1'b0;
         qByte_reg <= 8'h00;
         idx_reg <= 3'h0;
         crc_reg <= rsmh_pkg::CRC_INIT;
         bcast_reg <= 1'b0;
         refused_reg <= 1'b0;
         wait_reg <= '0;
         for (int i = 0; i < 6; i++) begin
            qb_reg[i] <= 8'h00;
         end
      end else begin
         cmdReady_reg <= state_reg == M_IDLE && !(cmdValid && cmdReady_reg);
         rReady_reg <= state_reg == M_WAIT && !rxStall;
         qStb_reg <= 1'b0;
         unique case (state_reg)
            M_IDLE: begin
               if (cmdValid && cmdReady_reg) begin
                  qb_reg[0] <= cmdAddr;
                  qb_reg[1] <= cmdFunc;
                  qb_reg[2] <= cmdWord0[15:8];
                  qb_reg[3] <= cmdWord0[7:0];
                  qb_reg[4] <= cmdWord1[15:8];
                  qb_reg[5] <= cmdWord1[7:0];
                  bcast_reg <= cmdAddr == rsmh_pkg::ADDR_BCAST;
                  refused_reg <= refuse;
                  idx_reg <= 3'h0;
                  crc_reg <= rsmh_pkg::CRC_INIT;
                  state_reg <= refuse ? M_DONE : M_GAP;
               end
            end
            M_GAP: begin
               if (idle_reg == SIL) begin
                  state_reg <= M_SEND;
               end
            end
            M_SEND: begin
               qStb_reg <= 1'b1;
               qByte_reg <= nextByte;
               idx_reg <= idx_reg + 3'h1;
               if (idx_reg < 3'h6) begin
                  crc_reg <= rsmh_pkg::crc16_next(crc_reg, nextByte);
               end
               if (idx_reg == 3'h7) begin
                  wait_reg <= '0;
                  state_reg <= M_WAIT;
               end
            end
            M_WAIT: begin
               if (wait_reg != RLIM) begin
                  wait_reg <= wait_reg + 1'b1;
               end
               if (idle_reg == SIL && !qStb_reg && (bcast_reg || rCnt_reg != 8'h00 || wait_reg == RLIM)) begin
                  state_reg <= M_DONE;
               end
            end
            M_DONE: begin
               state_reg <= M_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rCnt_reg <= 8'h00;
         rCrc_reg <= rsmh_pkg::CRC_INIT;
         for (int i = 0; i < 5; i++) begin
            rb_reg[i] <= 8'h00;
         end
      end else if (state_reg == M_SEND) begin
         rCnt_reg <= 8'h00;
         rCrc_reg <= rsmh_pkg::CRC_INIT;
      end else if (take) begin
         if (rCnt_reg < 8'h05) begin
            rb_reg[rCnt_reg[2:0]] <= link.rByte;
         end
         if (rCnt_reg != 8'hFF) begin
            rCnt_reg <= rCnt_reg + 8'h01;
         end
         rCrc_reg <= rsmh_pkg::crc16_next(rCrc_reg, link.rByte);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         respValid_reg <= 1'b0;
         respStatus_reg <= rsmh_pkg::ST_OK;
         respFunc_reg <= 8'h00;
         respCode_reg <= 8'h00;
         respWord_reg <= 16'h0000;
      end else begin
         respValid_reg <= state_reg == M_DONE;
         if (state_reg == M_DONE) begin
            respFunc_reg <= rb_reg[1];
            respCode_reg <= rb_reg[2];
            respWord_reg <= {rb_reg[3], rb_reg[4]};
            if (refused_reg) begin
               respStatus_reg <= rsmh_pkg::ST_REFUSED;
            end else if (bcast_reg) begin
               respStatus_reg <= rsmh_pkg::ST_OK;
            end else if (rCnt_reg == 8'h00) begin
               respStatus_reg <= rsmh_pkg::ST_NONE;
            end else if (rCnt_reg < 8'(rsmh_pkg::MIN_LEN) || rCrc_reg != 16'h0000) begin
               respStatus_reg <= rsmh_pkg::ST_BAD;
            end else if (rb_reg[1][7]) begin
               respStatus_reg <= rsmh_pkg::ST_EXC;
            end else begin
               respStatus_reg <= rsmh_pkg::ST_OK;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- logic/rsmh_pair_buf.sv ----
// Two-entry valid/ready byte buffer
`timescale 1ns/1ps
`default_nettype none
module rsmh_pair_buf (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [7:0] outData,
   output logic outValid,
   input wire logic outReady
);
   logic [7:0] slot_reg [2];
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign inReady = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData = slot_reg[0];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 2'h0;
      end else begin
         count_reg <= count_reg + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slot_reg[0] <= 8'h00;
         slot_reg[1] <= 8'h00;
      end else begin
         if (pop) begin
            slot_reg[0] <= (count_reg == 2'h2) ? slot_reg[1] : inData;
         end else if (push && count_reg == 2'h0) begin
            slot_reg[0] <= inData;
         end
         if (push && ((count_reg == 2'h1 && !pop) || (count_reg == 2'h2))) begin
            slot_reg[1] <= inData;
         end
      end
   end
endmodule
`default_nettype wire

// ---- logic/rsmh_pkg.sv ----
// Shared constants and CRC helper for the RTU message handler
package rsmh_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam longint unsigned BIT_RATE_BPS = 19200;
   localparam longint unsigned CHAR_BITS = 11;
   localparam longint unsigned SILENCE_CHARS_X10 = 35;
   localparam longint unsigned SILENCE_NS =
      (SILENCE_CHARS_X10 * CHAR_BITS * 64'd1000000000 + 64'd10 * BIT_RATE_BPS - 64'd1) / (64'd10 * BIT_RATE_BPS);
   localparam int unsigned SILENCE_CYC = int'((SILENCE_NS * CLK_MHZ + 64'd999) / 64'd1000);
   localparam longint unsigned RESP_LIMIT_MS = 50;
   localparam int unsigned RESP_CYC = int'(RESP_LIMIT_MS * CLK_MHZ * 64'd1000);
   localparam int unsigned CNT_W = 24;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_MAX = 8'hF7;
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_WRITE = 8'h06;
   localparam logic [7:0] FN_DIAG = 8'h08;
   localparam logic [7:0] EXC_BIT = 8'h80;
   localparam logic [7:0] EXC_ILL_FN = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_DATA = 8'h03;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] DIAG_ECHO = 16'h0000;
   localparam logic [15:0] RESET_REG = 16'h0FFF;
   localparam logic [15:0] MAX_READ = 16'h007D;
   localparam int unsigned REG_COUNT = 16;
   localparam logic [3:0] QUERY_LEN = 4'h8;
   localparam logic [3:0] MIN_LEN = 4'h4;
   localparam logic [7:0] ECHO_LEN = 8'h06;
   localparam logic [7:0] EXC_LEN = 8'h03;
   localparam logic [7:0] READ_HDR = 8'h03;
   localparam logic [2:0] ST_OK = 3'h0;
   localparam logic [2:0] ST_EXC = 3'h1;
   localparam logic [2:0] ST_BAD = 3'h2;
   localparam logic [2:0] ST_NONE = 3'h3;
   localparam logic [2:0] ST_REFUSED = 3'h4;

   function automatic logic [15:0] crc16_next(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

// ---- logic/rsmh_slave.sv ----
// Slave end: frames queries, checks them, executes and answers
//
// Behaviour
// [R1] Address byte 0..247, 0 is broadcast
// [R2] Reply address equals query address
// [R3] Station number setting is own address
// [R4] Master sends function code 1..255
// [R5] Support 03, 06, 08; others get error
// [R6] Normal reply copies function code
// [R7] Error reply sets bit 7, code in data
// [R8] Read and diagnostics never broadcast
// [R9] Single register write runs on broadcast
// [R10] 3.5 character silence delimits a message
// [R11] Address, function, data, CRC in order
// [R12] Execute query then send normal reply
// [R13] Bad function, address or data: error reply
// [R14] No reply on receive or CRC error
// [R15] Broadcast executes without any reply
// [R16] Broadcast ignores own station number
// [R17] Slave transmits only answering a query
// [R18] Fast requests processed under 20 ms
// [R19] Parameter requests processed under 50 ms
// [R20] Reset command produces no answer
// [R21] CRC low byte sent before high
// [R22] Recompute CRC on receive, mismatch is error
// [R23] Eight data bits per character
`timescale 1ns/1ps
`default_nettype none
module rsmh_slave #(
   parameter int unsigned SILENCE_CYC = rsmh_pkg::SILENCE_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   rsmh_link_if.slave link,
   input wire logic [7:0] stationNumberSetting,
   output logic regWrStb,
   output logic [15:0] regWrAddr,
   output logic [15:0] regWrData,
   output logic resetCmd,
   output logic [15:0] errCount
);
   typedef enum logic [1:0] {S_RX, S_EVAL, S_TX} rsmh_sst_t;
   typedef enum logic [1:0] {K_ECHO, K_READ, K_EXC} rsmh_kind_t;

   localparam logic [rsmh_pkg::CNT_W-1:0] SIL = rsmh_pkg::CNT_W'(SILENCE_CYC);

   rsmh_sst_t state_reg;
   rsmh_kind_t kind_reg;
   logic [7:0] rxBuf_reg [rsmh_pkg::QUERY_LEN];
   logic [15:0] holdReg_reg [rsmh_pkg::REG_COUNT];
   logic [3:0] rxCnt_reg;
   logic rxOvf_reg;
   logic rxErr_reg;
   logic rxActive_reg;
   logic [15:0] rxCrc_reg;
   logic [rsmh_pkg::CNT_W-1:0] idle_reg;
   logic [7:0] txIdx_reg;
   logic [7:0] txLen_reg;
   logic [7:0] excCode_reg;
   logic [15:0] txCrc_reg;
   logic [3:0] start_reg;
   logic regWrStb_reg;
   logic [15:0] regWrAddr_reg;
   logic [15:0] regWrData_reg;
   logic resetCmd_reg;
   logic [15:0] errCount_reg;

   logic rxTake;
   logic frameEnd;
   logic frameOk;
   logic bcast;
   logic mine;
   logic [15:0] w0;
   logic [15:0] w1;
   logic evReply;
   logic evWrite;
   logic evReset;
   rsmh_kind_t evKind;
   logic [7:0] evCode;
   logic [7:0] evLen;
   logic [7:0] txByte;
   logic [15:0] rdWord;
   logic [7:0] rdOff;
   logic bufInReady;
   logic txPush;

   assign regWrStb = regWrStb_reg;
   assign regWrAddr = regWrAddr_reg;
   assign regWrData = regWrData_reg;
   assign resetCmd = resetCmd_reg;
   assign errCount = errCount_reg;

   // [R17] Ignore line while answering
   assign rxTake = link.qStb && state_reg == S_RX && !link.rValid;
   // [R10] Silence ends the message
   assign frameEnd = state_reg == S_RX && rxActive_reg && idle_reg == SIL;
   // [R22] Residual zero means CRC matched
   assign frameOk = !rxErr_reg && !rxOvf_reg && rxCnt_reg >= rsmh_pkg::MIN_LEN && rxCrc_reg == 16'h0000;
   // [R16] Broadcast independent of station
   assign bcast = rxBuf_reg[0] == rsmh_pkg::ADDR_BCAST;
   // [R3] Match own station number
   assign mine = rxBuf_reg[0] == stationNumberSetting && rxBuf_reg[0] <= rsmh_pkg::ADDR_MAX;
   // [R11] Fixed field positions
   assign w0 = {rxBuf_reg[2], rxBuf_reg[3]};
   assign w1 = {rxBuf_reg[4], rxBuf_reg[5]};

   always_comb begin
      evReply = 1'b0;
      evWrite = 1'b0;
      evReset = 1'b0;
      evKind = K_EXC;
      evCode = rsmh_pkg::EXC_ILL_DATA;
      evLen = rsmh_pkg::EXC_LEN;
      // [R1] Own address or broadcast only
      if (frameOk && (bcast || mine)) begin
         // [R15] Broadcast never replies
         evReply = !bcast;
         case (rxBuf_reg[1])
            rsmh_pkg::FN_READ: begin
               // [R8] Broadcast read dropped
               evReply = !bcast;
               if (rxCnt_reg != rsmh_pkg::QUERY_LEN || w1 == 16'h0000 || w1 > rsmh_pkg::MAX_READ) begin
                  evCode = rsmh_pkg::EXC_ILL_DATA;
               end else if ({1'b0, w0} + {1'b0, w1} > 17'(rsmh_pkg::REG_COUNT)) begin
                  evCode = rsmh_pkg::EXC_ILL_ADDR;
               end else begin
                  evKind = K_READ;
                  evLen = rsmh_pkg::READ_HDR + 8'({w1[6:0], 1'b0});
               end
            end
            rsmh_pkg::FN_WRITE: begin
               if (rxCnt_reg != rsmh_pkg::QUERY_LEN) begin
                  evCode = rsmh_pkg::EXC_ILL_DATA;
               end else if (w0 == rsmh_pkg::RESET_REG) begin
                  // [R20] Reset runs silently
                  evReset = 1'b1;
                  evReply = 1'b0;
               end else if (w0 >= 16'(rsmh_pkg::REG_COUNT)) begin
                  // [R13] Bad register address
                  evCode = rsmh_pkg::EXC_ILL_ADDR;
               end else begin
                  // [R9] Write also on broadcast
                  evWrite = 1'b1;
                  evKind = K_ECHO;
                  evLen = rsmh_pkg::ECHO_LEN;
               end
            end
            rsmh_pkg::FN_DIAG: begin
               if (rxCnt_reg == rsmh_pkg::QUERY_LEN && w0 == rsmh_pkg::DIAG_ECHO) begin
                  evKind = K_ECHO;
                  evLen = rsmh_pkg::ECHO_LEN;
               end
            end
            default: begin
               // [R5] Unsupported function
               evCode = rsmh_pkg::EXC_ILL_FN;
            end
         endcase
      end
   end

   assign rdOff = txIdx_reg - rsmh_pkg::READ_HDR;
   assign rdWord = holdReg_reg[start_reg + rdOff[4:1]];

   always_comb begin
      txByte = 8'h00;
      if (txIdx_reg == txLen_reg) begin
         // [R21] CRC low byte first
         txByte = txCrc_reg[7:0];
      end else if (txIdx_reg > txLen_reg) begin
         txByte = txCrc_reg[15:8];
      end else if (txIdx_reg == 8'h00) begin
         // [R2] Echo query address
         txByte = rxBuf_reg[0];
      end else if (txIdx_reg == 8'h01) begin
         // [R6] [R7] Function copy or flagged
         txByte = (kind_reg == K_EXC) ? (rxBuf_reg[1] | rsmh_pkg::EXC_BIT) : rxBuf_reg[1];
      end else if (kind_reg == K_ECHO) begin
         txByte = rxBuf_reg[txIdx_reg[2:0]];
      end else if (kind_reg == K_EXC) begin
         txByte = excCode_reg;
      end else if (txIdx_reg == 8'h02) begin
         txByte = txLen_reg - rsmh_pkg::READ_HDR;
      end else begin
         txByte = rdOff[0] ? rdWord[7:0] : rdWord[15:8];
      end
   end

   assign txPush = state_reg == S_TX && bufInReady;

   // [R10] Silence counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= '0;
      end else if (rxTake || txPush) begin
         idle_reg <= '0;
      end else if (idle_reg != SIL) begin
         idle_reg <= idle_reg + 1'b1;
      end
   end

   // [R23] One byte per character
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxCnt_reg <= 4'h0;
         rxOvf_reg <= 1'b0;
         rxErr_reg <= 1'b0;
         rxActive_reg <= 1'b0;
         rxCrc_reg <= rsmh_pkg::CRC_INIT;
         for (int i = 0; i < rsmh_pkg::QUERY_LEN; i++) begin
            rxBuf_reg[i] <= 8'h00;
         end
      end else if (rxTake) begin
         rxActive_reg <= 1'b1;
         // [R14] Receive error poisons frame
         rxErr_reg <= rxErr_reg | link.qErr;
         // [R22] Running CRC
         rxCrc_reg <= rsmh_pkg::crc16_next(rxCrc_reg, link.qByte);
         if (rxCnt_reg == rsmh_pkg::QUERY_LEN) begin
            rxOvf_reg <= 1'b1;
         end else begin
            rxBuf_reg[rxCnt_reg[2:0]] <= link.qByte;
            rxCnt_reg <= rxCnt_reg + 4'h1;
         end
      end else if (state_reg == S_EVAL) begin
         rxCnt_reg <= 4'h0;
         rxOvf_reg <= 1'b0;
         rxErr_reg <= 1'b0;
         rxActive_reg <= 1'b0;
         rxCrc_reg <= rsmh_pkg::CRC_INIT;
      end
   end

   // [R12] [R18] [R19] Evaluate one cycle after silence
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_RX;
      end else begin
         unique case (state_reg)
            S_RX: begin
               if (frameEnd) begin
                  state_reg <= S_EVAL;
               end
            end
            S_EVAL: begin
               // [R14] Errors end silently
               state_reg <= evReply ? S_TX : S_RX;
            end
            S_TX: begin
               if (txPush && txIdx_reg > txLen_reg) begin
                  state_reg <= S_RX;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         kind_reg <= K_EXC;
         excCode_reg <= 8'h00;
         txLen_reg <= 8'h00;
         txIdx_reg <= 8'h00;
         txCrc_reg <= rsmh_pkg::CRC_INIT;
         start_reg <= 4'h0;
      end else if (state_reg == S_EVAL) begin
         kind_reg <= evKind;
         excCode_reg <= evCode;
         txLen_reg <= evLen;
         txIdx_reg <= 8'h00;
         txCrc_reg <= rsmh_pkg::CRC_INIT;
         start_reg <= w0[3:0];
      end else if (txPush) begin
         txIdx_reg <= txIdx_reg + 8'h01;
         if (txIdx_reg < txLen_reg) begin
            txCrc_reg <= rsmh_pkg::crc16_next(txCrc_reg, txByte);
         end
      end
   end

   // [R9] [R12] Execute write and reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regWrStb_reg <= 1'b0;
         regWrAddr_reg <= 16'h0000;
         regWrData_reg <= 16'h0000;
         resetCmd_reg <= 1'b0;
         for (int i = 0; i < rsmh_pkg::REG_COUNT; i++) begin
            holdReg_reg[i] <= 16'h0000;
         end
      end else begin
         regWrStb_reg <= state_reg == S_EVAL && evWrite;
         resetCmd_reg <= state_reg == S_EVAL && evReset;
         if (state_reg == S_EVAL && evWrite) begin
            regWrAddr_reg <= w0;
            regWrData_reg <= w1;
            holdReg_reg[w0[3:0]] <= w1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         errCount_reg <= 16'h0000;
      end else if (state_reg == S_EVAL && !frameOk && errCount_reg != 16'hFFFF) begin
         errCount_reg <= errCount_reg + 16'h0001;
      end
   end

   rsmh_pair_buf txBuf (
      .mclk(mclk),
      .rst_n(rst_n),
      .inData(txByte),
      .inValid(state_reg == S_TX),
      .inReady(bufInReady),
      .outData(link.rByte),
      .outValid(link.rValid),
      .outReady(link.rReady)
   );
endmodule
`default_nettype wire

// ---- tb/rsmh_props.sv ----
// Link checker for the query and answer exchange
`timescale 1ns/1ps
`default_nettype none
module rsmh_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] qByte,
   input wire logic qStb,
   input wire logic qErr,
   input wire logic [7:0] rByte,
   input wire logic rValid,
   input wire logic rReady
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence q_burst; qStb [*8] ##1 !qStb; endsequence
   sequence r_quiet; !rValid [*8]; endsequence
   addr_range_a: assert property ($rose(qStb) |-> qByte <= 8'hF7)
      else $error("query address above range");
   q_burst_a: assert property ($rose(qStb) |-> q_burst)
      else $error("query burst length wrong");
   err_flag_a: assert property (!qErr)
      else $error("master flagged a byte");
   reply_addr_a: assert property ($rose(rValid) |-> rByte != 8'h00 && rByte <= 8'hF7)
      else $error("reply with broadcast or bad address");
   r_hold_a: assert property (rValid && !rReady |=> rValid && $stable(rByte))
      else $error("reply byte lost under stall");
   half_duplex_a: assert property (rValid |-> !qStb)
      else $error("query during reply");
   answer_wait_a: assert property ($fell(qStb) |-> r_quiet)
      else $error("reply before silence");
   query_quiet_a: assert property ($rose(qStb) |-> r_quiet)
      else $error("reply during query");
   reply_start_a: assert property ($rose(rValid) |-> !$past(qStb))
      else $error("reply right after byte");
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench joining master and slave ends of the link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0, rst_n = 1'b0, cmdValid = 1'b0, rxStall = 1'b0;
   logic respValid, cmdReady, regWrStb, resetCmd;
   logic [7:0] station = 8'h05, cmdAddr = 8'h00, cmdFunc = 8'h00, respFunc, respCode;
   logic [15:0] cmdWord0 = 16'h0000, cmdWord1 = 16'h0000, respWord, regWrAddr, regWrData, errCount, errCountB;
   logic [2:0] respStatus;
   int n_mismatch = 0, tests_run = 0, wrSeen = 0, rstSeen = 0;
   rsmh_link_if link();
   rsmh_link_if linkB();
   rsmh_master #(.SILENCE_CYC(16), .RESP_CYC(200)) i_rsmh_master (.mclk(mclk), .rst_n(rst_n), .link(link),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdFunc(cmdFunc), .cmdWord0(cmdWord0),
      .cmdWord1(cmdWord1), .rxStall(rxStall), .respValid(respValid), .respStatus(respStatus),
      .respFunc(respFunc), .respCode(respCode), .respWord(respWord));
   rsmh_slave #(.SILENCE_CYC(16)) i_rsmh_slave (.mclk(mclk), .rst_n(rst_n), .link(link),
      .stationNumberSetting(station), .regWrStb(regWrStb), .regWrAddr(regWrAddr), .regWrData(regWrData),
      .resetCmd(resetCmd), .errCount(errCount));
   rsmh_slave #(.SILENCE_CYC(16)) i_rsmh_slave_b (.mclk(mclk), .rst_n(rst_n), .link(linkB),
      .stationNumberSetting(station), .regWrStb(), .regWrAddr(), .regWrData(), .resetCmd(),
      .errCount(errCountB));
   rsmh_props i_rsmh_props (.mclk(mclk), .rst_n(rst_n), .qByte(link.qByte), .qStb(link.qStb),
      .qErr(link.qErr), .rByte(link.rByte), .rValid(link.rValid), .rReady(link.rReady));
   initial begin
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (regWrStb === 1'b1) wrSeen <= wrSeen + 1;
      if (resetCmd === 1'b1) rstSeen <= rstSeen + 1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic run(input logic [7:0] a, input logic [7:0] f, input logic [15:0] w0, input logic [15:0] w1);
      int i;
      i = 0;
      while (cmdReady !== 1'b1 && i < 600) begin
         @(negedge mclk);
         i++;
      end
      cmdAddr = a;
      cmdFunc = f;
      cmdWord0 = w0;
      cmdWord1 = w1;
      cmdValid = 1'b1;
      @(negedge mclk);
      cmdValid = 1'b0;
      while (respValid !== 1'b1 && i < 600) begin
         @(negedge mclk);
         i++;
      end
      if (i >= 600) begin
         n_mismatch++;
         $display("mismatch at %0t: no answer", $time);
         wrap_up();
      end
   endtask
   task automatic t_write;
      run(8'h05, 8'h06, 16'h0002, 16'h1234);
      chk(16'(respStatus), 16'h0000);
      chk(16'(respFunc), 16'h0006);
      chk(16'(respCode), 16'h0000);
      chk(respWord, 16'h0212);
      chk(regWrAddr, 16'h0002);
      chk(regWrData, 16'h1234);
      $display("t_write done");
   endtask
   task automatic t_read;
      rxStall = 1'b1;
      fork
         begin
            repeat (60) @(negedge mclk);
            rxStall = 1'b0;
         end
      join_none
      run(8'h05, 8'h03, 16'h0002, 16'h0001);
      chk(16'(respStatus), 16'h0000);
      chk(16'(respCode), 16'h0002);
      chk(respWord, 16'h1234);
      $display("t_read done");
   endtask
   task automatic t_exc;
      run(8'h05, 8'h07, 16'h0000, 16'h0000);
      chk(16'(respStatus), 16'h0001);
      chk(16'(respFunc), 16'h0087);
      chk(16'(respCode), 16'h0001);
      run(8'h05, 8'h06, 16'h0014, 16'h0001);
      chk(16'(respCode), 16'h0002);
      run(8'h05, 8'h03, 16'h0000, 16'h0000);
      chk(16'(respCode), 16'h0003);
      run(8'h05, 8'h08, 16'h0000, 16'h0000);
      chk(16'(respFunc), 16'h0008);
      $display("t_exc done");
   endtask
   task automatic t_bcast;
      station = 8'h09;
      run(8'h05, 8'h03, 16'h0000, 16'h0001);
      chk(16'(respStatus), 16'h0003);
      run(8'h00, 8'h06, 16'h0003, 16'h0055);
      chk(regWrAddr, 16'h0003);
      chk(regWrData, 16'h0055);
      chk(16'(link.rValid), 16'h0000);
      run(8'h00, 8'h03, 16'h0000, 16'h0001);
      chk(16'(respStatus), 16'h0004);
      run(8'h09, 8'h06, 16'h0FFF, 16'h0001);
      chk(16'(rstSeen), 16'h0001);
      chk(16'(respStatus), 16'h0003);
      chk(16'(wrSeen), 16'h0002);
      chk(errCount, 16'h0000);
      $display("t_bcast done");
   endtask
   task automatic t_fault;
      for (int k = 0; k < 8; k++) begin
         linkB.qByte = 8'(k + 1);
         linkB.qStb = 1'b1;
         linkB.qErr = (k == 3);
         @(negedge mclk);
      end
      linkB.qStb = 1'b0;
      linkB.qErr = 1'b0;
      repeat (40) @(negedge mclk);
      chk(errCountB, 16'h0001);
      chk(16'(linkB.rValid), 16'h0000);
      $display("t_fault done");
   endtask
   initial begin
      linkB.qByte = 8'h00;
      linkB.qStb = 1'b0;
      linkB.qErr = 1'b0;
      linkB.rReady = 1'b1;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      t_write();
      t_read();
      t_exc();
      t_bcast();
      t_fault();
      wrap_up();
   end
endmodule
`default_nettype wire
